//--- poi_pkg.sv
package poi_pkg;

  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int PIX_W      = 12;   // parallel pixel bus
  localparam int WORD_W     = 16;   // widest serial word
  localparam int LANES      = 4;    // serial data lanes
  localparam int DLY_W      = 3;    // eighth-UI delay code
  localparam int FIFO_DEPTH = 4;    // pixel buffer words
  localparam int CNT_W      = 16;   // row and column counters

  // ----------------------------------------
  // clock rates, kHz
  // ----------------------------------------
  localparam int SYS_CLK_KHZ    = 250000;
  localparam int MASTER_CLK_KHZ = 24000;
  localparam int ARRAY_PIX_KHZ  = 110000;
  localparam int OUT_PIX_KHZ    = 55000;
  // half period of the output pixel clock, rounded down
  localparam int OUT_PIX_HALF   = SYS_CLK_KHZ / (2 * OUT_PIX_KHZ);

  // ----------------------------------------
  // delay codes
  // ----------------------------------------
  localparam logic [DLY_W:0]   DLY_ZERO         = 4'h0;
  // half a UI in eighth-UI steps: 90 degrees of the ddr clock
  localparam logic [DLY_W:0]   CLK_LANE_QUARTER = 4'h4;

  // ----------------------------------------
  // serial word length codes, cycles per word
  // ----------------------------------------
  localparam logic [1:0] WMODE_10 = 2'h0;
  localparam logic [1:0] WMODE_12 = 2'h1;
  localparam logic [1:0] WMODE_14 = 2'h2;
  localparam logic [1:0] WMODE_16 = 2'h3;
  localparam logic [3:0] CYC_10   = 4'h5;
  localparam logic [3:0] CYC_12   = 4'h6;
  localparam logic [3:0] CYC_14   = 4'h7;
  localparam logic [3:0] CYC_16   = 4'h8;

  // ----------------------------------------
  // raw formats and lane counts
  // ----------------------------------------
  localparam logic [1:0]       FMT_RAW8  = 2'h0;
  localparam logic [1:0]       FMT_RAW10 = 2'h1;
  localparam logic [PIX_W-1:0] MASK_RAW8  = 12'hFF0;
  localparam logic [PIX_W-1:0] MASK_RAW10 = 12'hFFC;
  localparam logic [PIX_W-1:0] MASK_RAW12 = 12'hFFF;
  localparam logic [1:0]       LANES_1 = 2'h0;
  localparam logic [1:0]       LANES_2 = 2'h1;
  localparam logic [2:0]       NUM_1   = 3'h1;
  localparam logic [2:0]       NUM_2   = 3'h2;
  localparam logic [2:0]       NUM_4   = 3'h4;
  localparam logic [WORD_W-1:0] SYNC_WORD = 16'hFFFF;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SYNC  = 4'b0010,
    ST_ACT   = 4'b0100,
    ST_BLANK = 4'b1000
  } poi_state_e;

endpackage

//--- poi_fifo.sv
`timescale 1ns/10ps
module poi_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  output logic [W-1:0]      outData,
  output logic              outValid,
  input  wire logic         outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];   // storage
  logic [AW-1:0] wrPtr;         // wraps, depth is a power of two
  logic [AW-1:0] rdPtr;
  logic [AW:0]   count;         // words held
  logic [AW:0]   next_count;
  logic          push;
  logic          pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  // occupancy after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // pointers, count and a registered ready
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr   <= '0;
      rdPtr   <= '0;
      count   <= '0;
      inReady <= 1'b1;
    end else if (clkEn) begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count   <= next_count;
      inReady <= (next_count != (AW+1)'(DEPTH));
    end
  end

  // storage has no reset
  always_ff @(posedge clk) begin
    if (clkEn && push) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

//--- poi_lane_ser.sv
`timescale 1ns/10ps
module poi_lane_ser #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         clkEn,
  input  wire logic         load,
  input  wire logic [W-1:0] word,
  output logic              riseBit,
  output logic              fallBit
);
  logic [W-1:0] shiftReg;   // bits still to send, msb aligned

  // two bits per cycle: first on the rising half, next on the falling
  always_ff @(posedge clk) begin
    if (reset) begin
      shiftReg <= '0;
      riseBit  <= 1'b0;
      fallBit  <= 1'b0;
    end else if (clkEn) begin
      if (load) begin
        riseBit  <= word[W-1];
        fallBit  <= word[W-2];
        shiftReg <= {word[W-3:0], 2'b00};
      end else begin
        riseBit  <= shiftReg[W-1];
        fallBit  <= shiftReg[W-2];
        shiftReg <= {shiftReg[W-3:0], 2'b00};
      end
    end
  end
endmodule

//--- poi_pixel_output.sv
`timescale 1ns/10ps
module poi_pixel_output #(
  parameter int PIX_HALF = poi_pkg::OUT_PIX_HALF,
  parameter int DEPTH    = poi_pkg::FIFO_DEPTH
) (
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic                              clkEn,
  input  wire logic                              standby,
  input  wire logic                              cfgSerialMode,
  input  wire logic [1:0]                        cfgLaneCount,
  input  wire logic [1:0]                        cfgWordMode,
  input  wire logic [1:0]                        cfgRawFormat,
  input  wire logic [poi_pkg::CNT_W-1:0]         cfgActiveCols,
  input  wire logic [poi_pkg::CNT_W-1:0]         cfgHBlank,
  input  wire logic [poi_pkg::CNT_W-1:0]         cfgActiveRows,
  input  wire logic [poi_pkg::CNT_W-1:0]         cfgVBlank,
  input  wire logic [1:0]                        cfgPixClkDelay,
  input  wire logic [poi_pkg::LANES*poi_pkg::DLY_W-1:0] cfgLaneDelay,
  input  wire logic [poi_pkg::DLY_W-1:0]         cfgClkLaneDelay,
  input  wire logic                              dllLocked,
  input  wire logic [poi_pkg::PIX_W-1:0]         pixIn,
  input  wire logic                              pixInValid,
  output logic                                   pixInReady,
  output logic                                   rowActiveFlag,
  output logic                                   frameActiveFlag,
  output logic [poi_pkg::PIX_W-1:0]              pixData,
  output logic                                   outputPixelClock,
  output logic [poi_pkg::LANES-1:0]              laneRise,
  output logic [poi_pkg::LANES-1:0]              laneFall,
  output logic                                   clkLaneRun,
  output logic [poi_pkg::LANES*(poi_pkg::DLY_W+1)-1:0] laneDelayCode,
  output logic [poi_pkg::DLY_W:0]                clkLaneDelayCode,
  output logic                                   underrun
);
  localparam int PERIOD = 2 * PIX_HALF;
  localparam int PH_W   = $clog2(PERIOD) + 1;
  localparam int PW     = poi_pkg::PIX_W;
  localparam int CW     = poi_pkg::CNT_W;
  localparam int NL     = poi_pkg::LANES;
  localparam int DW     = poi_pkg::DLY_W;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  // configuration held steady outside standby
  logic          serial;                 // serial path selected
  logic [1:0]    laneSel;                // active lane code
  logic [1:0]    wordSel;                // word length code
  logic [1:0]    fmtSel;                 // raw format code
  logic [CW-1:0] activeCols;
  logic [CW-1:0] hBlank;
  logic [CW-1:0] activeRows;
  logic [CW-1:0] vBlank;
  // timing
  logic [PH_W-1:0] phase;                // output pixel clock phase
  logic [PH_W-1:0] next_phase;
  logic            phaseLast;
  logic [3:0]      wordCnt;              // cycles into a serial word
  logic [3:0]      wordCycles;           // cycles per serial word
  logic            wordLast;
  logic            slotTick;             // one slot ends this cycle
  logic            next_output_sample_clock;
  // raster
  poi_pkg::poi_state_e state;
  poi_pkg::poi_state_e next_state;
  logic [CW-1:0]   col;
  logic [CW-1:0]   next_col;
  logic [CW-1:0]   row;
  logic [CW-1:0]   next_row;
  logic            vRow;                 // current row is vertical blanking
  logic [CW-1:0]   blankLen;
  logic [CW-1:0]   rowsTotal;
  // prefetch of pixels for the next slot
  logic [PW-1:0]   hold [NL];
  logic [2:0]      holdCnt;
  logic [2:0]      need;                 // pixels per active slot
  logic [PW-1:0]   fmtMask;
  logic [PW-1:0]   fifoData;
  logic            fifoValid;
  logic            fifoPop;
  logic            consume;              // slot into active pixels
  logic [poi_pkg::WORD_W-1:0] laneWord [NL];

  // ----------------------------------------
  // pixel buffer
  // ----------------------------------------
  poi_fifo #(
    .W     (PW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset    (reset),
    .clkEn    (clkEn),
    .inData   (pixIn),
    .inValid  (pixInValid),
    .inReady  (pixInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // ----------------------------------------
  // configuration capture
  // ----------------------------------------
  // setup taken only in standby
  always_ff @(posedge clk) begin
    if (reset) begin
      serial     <= 1'b0;
      laneSel    <= poi_pkg::LANES_1;
      wordSel    <= poi_pkg::WMODE_12;
      fmtSel     <= poi_pkg::FMT_RAW8;
      activeCols <= '0;
      hBlank     <= '0;
      activeRows <= '0;
      vBlank     <= '0;
    end else if (clkEn && standby) begin
      serial     <= cfgSerialMode;
      laneSel    <= cfgLaneCount;
      wordSel    <= cfgWordMode;
      fmtSel     <= cfgRawFormat;
      activeCols <= cfgActiveCols;
      hBlank     <= cfgHBlank;
      activeRows <= cfgActiveRows;
      vBlank     <= cfgVBlank;
    end
  end

  // decoded setup
  always_comb begin
    // word length selects cycles per word
    unique case (wordSel)
      poi_pkg::WMODE_10: wordCycles = poi_pkg::CYC_10;
      poi_pkg::WMODE_12: wordCycles = poi_pkg::CYC_12;
      poi_pkg::WMODE_14: wordCycles = poi_pkg::CYC_14;
      default:           wordCycles = poi_pkg::CYC_16;
    endcase
    // unused low bits forced to zero
    unique case (fmtSel)
      poi_pkg::FMT_RAW8:  fmtMask = poi_pkg::MASK_RAW8;
      poi_pkg::FMT_RAW10: fmtMask = poi_pkg::MASK_RAW10;
      default:            fmtMask = poi_pkg::MASK_RAW12;
    endcase
    // parallel path takes one pixel per slot
    if (!serial) begin
      need = poi_pkg::NUM_1;
    end else if (laneSel == poi_pkg::LANES_1) begin
      need = poi_pkg::NUM_1;
    end else if (laneSel == poi_pkg::LANES_2) begin
      need = poi_pkg::NUM_2;
    end else begin
      need = poi_pkg::NUM_4;
    end
  end

  // ----------------------------------------
  // slot timing
  // ----------------------------------------
  assign phaseLast  = (phase == PH_W'(PERIOD - 1));
  assign next_phase = phaseLast ? '0 : phase + 1'b1;
  assign wordLast   = (wordCnt == wordCycles - 1'b1);
  // a parallel slot is one pixel clock period
  assign slotTick   = serial ? wordLast : phaseLast;

  // default half period sets the output rate
  // free-running divider of the pll-fed clock
  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= '0;
    end else if (clkEn) begin
      phase <= next_phase;
    end
  end

  // serial word cycle counter
  always_ff @(posedge clk) begin
    if (reset) begin
      wordCnt <= '0;
    end else if (clkEn) begin
      wordCnt <= wordLast ? '0 : wordCnt + 1'b1;
    end
  end

  // rising edge half a period after the slot change
  // extra delay shifts the edge later, modulo a period
  always_comb begin
    int rel;
    rel = 0;
    rel = int'(next_phase) - PIX_HALF - int'(cfgPixClkDelay);
    if (rel < 0) begin
      rel = rel + PERIOD;
    end
    if (rel < 0) begin
      rel = rel + PERIOD;
    end
    next_output_sample_clock = (rel < PIX_HALF);
  end

  // clock runs in blanking and standby alike
  always_ff @(posedge clk) begin
    if (reset) begin
      outputPixelClock <= 1'b0;
    end else if (clkEn) begin
      outputPixelClock <= next_output_sample_clock;
    end
  end

  // ----------------------------------------
  // raster sequencer
  // ----------------------------------------
  // counter sums assume settings fit the counter width
  assign vRow      = (row >= activeRows);
  assign blankLen  = vRow ? activeCols + hBlank : hBlank;
  assign rowsTotal = activeRows + vBlank;

  // first slot of a row
  function automatic poi_pkg::poi_state_e rowStart(input logic ser,
                                                   input logic blankRow);
    // serial lines open with a sync slot
    if (ser) begin
      return poi_pkg::ST_SYNC;
    end else if (blankRow) begin
      return poi_pkg::ST_BLANK;
    end
    return poi_pkg::ST_ACT;
  endfunction

  // active pixels, then horizontal, then vertical blanking
  always_comb begin
    next_state = state;
    next_col   = col;
    next_row   = row;
    if (standby) begin
      next_state = poi_pkg::ST_IDLE;
      next_col   = '0;
      next_row   = '0;
    end else if (slotTick) begin
      unique case (state)
        poi_pkg::ST_IDLE: begin
          next_state = rowStart(serial, activeRows == '0);
        end
        poi_pkg::ST_SYNC: begin
          next_state = vRow ? poi_pkg::ST_BLANK : poi_pkg::ST_ACT;
        end
        poi_pkg::ST_ACT: begin
          if (col == activeCols - 1'b1) begin
            next_state = poi_pkg::ST_BLANK;
            next_col   = '0;
          end else begin
            next_col = col + 1'b1;
          end
        end
        poi_pkg::ST_BLANK: begin
          // a zero-length blank row must not occur: hBlank at least 1
          if (col == blankLen - 1'b1) begin
            next_col   = '0;
            next_row   = (row == rowsTotal - 1'b1) ? '0 : row + 1'b1;
            next_state = rowStart(serial, next_row >= activeRows);
          end else begin
            next_col = col + 1'b1;
          end
        end
        default: begin
          next_state = poi_pkg::ST_IDLE;
          next_col   = '0;
          next_row   = '0;
        end
      endcase
    end
  end

  // raster state
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= poi_pkg::ST_IDLE;
      col   <= '0;
      row   <= '0;
    end else if (clkEn) begin
      state <= next_state;
      col   <= next_col;
      row   <= next_row;
    end
  end

  // ----------------------------------------
  // pixel prefetch
  // ----------------------------------------
  // prefetch keeps the buffer drained only as fast as slots use it
  assign consume = slotTick && !standby && (next_state == poi_pkg::ST_ACT);
  assign fifoPop = fifoValid && (holdCnt < need) && !slotTick && !standby;

  // holding registers for the next active slot
  always_ff @(posedge clk) begin
    if (reset) begin
      holdCnt <= '0;
      for (int i = 0; i < NL; i++) begin
        hold[i] <= '0;
      end
    end else if (clkEn) begin
      if (standby || consume) begin
        holdCnt <= '0;
      end else if (fifoPop) begin
        hold[holdCnt[1:0]] <= fifoData;
        holdCnt            <= holdCnt + 1'b1;
      end
    end
  end

  // sticky starvation flag, cleared by standby; a new miss wins
  always_ff @(posedge clk) begin
    if (reset) begin
      underrun <= 1'b0;
    end else if (clkEn) begin
      if (consume && (holdCnt < need)) begin
        underrun <= 1'b1;
      end else if (standby) begin
        underrun <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // parallel outputs
  // ----------------------------------------
  // row flag follows active slots only
  // frame flag low through vertical blanking
  always_ff @(posedge clk) begin
    if (reset) begin
      rowActiveFlag   <= 1'b0;
      frameActiveFlag <= 1'b0;
    end else if (clkEn) begin
      rowActiveFlag   <= !serial && (next_state == poi_pkg::ST_ACT);
      frameActiveFlag <= !serial && (next_state != poi_pkg::ST_IDLE)
                         && (next_row < activeRows);
    end
  end

  // one pixel per slot, changed at the slot boundary
  // zero when no pixel is due
  always_ff @(posedge clk) begin
    if (reset) begin
      pixData <= '0;
    end else if (clkEn) begin
      if (standby || serial) begin
        pixData <= '0;
      end else if (slotTick) begin
        pixData <= (consume && holdCnt != '0) ? (hold[0] & fmtMask) : '0;
      end
    end
  end

  // ----------------------------------------
  // serial lanes
  // ----------------------------------------
  // four data lanes beside one clock lane
  generate
    for (genvar i = 0; i < NL; i++) begin : g_lane
      // sync word opens each line on every lane
      always_comb begin
        laneWord[i] = '0;
        if (serial && !standby && slotTick) begin
          if (next_state == poi_pkg::ST_SYNC) begin
            laneWord[i] = poi_pkg::SYNC_WORD;
          end else if (consume && (3'(i) < holdCnt) && (3'(i) < need)) begin
            laneWord[i] = {hold[i] & fmtMask, 4'h0};
          end
        end
      end

      // word time then restart; short words drop low bits
      poi_lane_ser #(
        .W (poi_pkg::WORD_W)
      ) u_ser (
        .clk     (clk),
        .reset   (reset),
        .clkEn   (clkEn),
        .load    (wordLast),
        .word    (laneWord[i]),
        .riseBit (laneRise[i]),
        .fallBit (laneFall[i])
      );
    end
  endgenerate

  // ddr clock lane runs while serial output is live
  // one bit per half cycle on the clock lane
  always_ff @(posedge clk) begin
    if (reset) begin
      clkLaneRun <= 1'b0;
    end else if (clkEn) begin
      clkLaneRun <= serial && !standby;
    end
  end

  // ----------------------------------------
  // lane delay control
  // ----------------------------------------
  // codes drive the per-lane delay buffers
  // codes move only while the dll holds lock
  always_ff @(posedge clk) begin
    if (reset) begin
      laneDelayCode <= '0;
    end else if (clkEn && dllLocked) begin
      for (int i = 0; i < NL; i++) begin
        laneDelayCode[i*(DW+1) +: DW+1] <= {1'b0, cfgLaneDelay[i*DW +: DW]};
      end
    end
  end

  // clock lane sits a quarter clock cycle plus cfgClkLaneDelay eighth-UI steps from data
  always_ff @(posedge clk) begin
    if (reset) begin
      clkLaneDelayCode <= poi_pkg::CLK_LANE_QUARTER;
    end else if (clkEn && dllLocked) begin
      clkLaneDelayCode <= poi_pkg::CLK_LANE_QUARTER + {1'b0, cfgClkLaneDelay};
    end
  end
endmodule

//--- poi_pixel_output_assertions.sv
`timescale 1ns/10ps
module poi_pixel_output_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        standby,
  input wire logic        dllLocked,
  input wire logic [11:0] cfgLaneDelay,
  input wire logic [2:0]  cfgClkLaneDelay,
  input wire logic        rowActiveFlag,
  input wire logic        frameActiveFlag,
  input wire logic [11:0] pixData,
  input wire logic        outputPixelClock,
  input wire logic [15:0] laneDelayCode,
  input wire logic [3:0]  clkLaneDelayCode
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [15:0] expDly;  // lane codes as the dll should load them
  always_comb expDly = {1'b0, cfgLaneDelay[11:9], 1'b0, cfgLaneDelay[8:6],
                        1'b0, cfgLaneDelay[5:3], 1'b0, cfgLaneDelay[2:0]};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // lag assumes a pixel clock delay code of 1
  property p_blank_zero; !rowActiveFlag |-> pixData == 12'h000; endproperty
  a_blank_zero: assert property (p_blank_zero) else $error("bus not zero in blank");
  property p_row_in_frame; rowActiveFlag |-> frameActiveFlag; endproperty
  a_row_in_frame: assert property (p_row_in_frame) else $error("row outside frame");
  property p_pclk_high; $rose(outputPixelClock) |=> outputPixelClock ##1 !outputPixelClock;
  endproperty
  a_pclk_high: assert property (p_pclk_high) else $error("pixel clock high phase");
  property p_pclk_low; $fell(outputPixelClock) |=> !outputPixelClock ##1 outputPixelClock;
  endproperty
  a_pclk_low: assert property (p_pclk_low) else $error("pixel clock low phase");
  property p_lag; !standby && $changed(rowActiveFlag) |-> ##3 $rose(outputPixelClock);
  endproperty
  a_lag: assert property (p_lag) else $error("pixel clock edge not after data");
  property p_dly_hold; !dllLocked |=> $stable(laneDelayCode) && $stable(clkLaneDelayCode);
  endproperty
  a_dly_hold: assert property (p_dly_hold) else $error("delay moved unlocked");
  property p_dly_load; dllLocked |=> laneDelayCode == $past(expDly); endproperty
  a_dly_load: assert property (p_dly_load) else $error("lane delay not loaded");
  property p_clk_lane;
    dllLocked |=> clkLaneDelayCode == poi_pkg::CLK_LANE_QUARTER + {1'b0, $past(cfgClkLaneDelay)};
  endproperty
  a_clk_lane: assert property (p_clk_lane) else $error("clock lane offset wrong");
  property p_standby; standby |=> !frameActiveFlag && !rowActiveFlag; endproperty
  a_standby: assert property (p_standby) else $error("flags up in standby");
endmodule
bind poi_pixel_output poi_pixel_output_checker u_poi_pixel_output_checker (.*);

//--- poi_rx_model.sv
`timescale 1ns/10ps
module poi_rx_model (
  input wire logic        clk,
  input wire logic        outputPixelClock,
  input wire logic        clear,
  input wire logic        rowActiveFlag,
  input wire logic [11:0] pixData,
  input wire logic        laneRise,
  input wire logic        laneFall,
  output logic [15:0]     pixCount,
  output logic [11:0]     firstPix,
  output logic [15:0]     serWord
);
  logic [15:0] serShift;  // last sixteen lane bits
  logic [3:0]  serLeft;   // captures still due after a sync word

  // serial lane 0: two bits per clk, one from each clock lane half
  // both edge capture
  always @(posedge clk or posedge clear) begin
    if (clear) begin
      serShift <= 16'h0000;
      serLeft  <= 4'h0;
      serWord  <= 16'h0000;
    end else begin
      serShift <= {serShift[13:0], laneRise, laneFall};
      if (serLeft == 4'h1) serWord <= serShift;
      if (serShift == 16'hFFFF) serLeft <= 4'h8;
      else if (serLeft != 4'h0) serLeft <= serLeft - 4'h1;
    end
  end

  // receiver samples only on the rising pixel clock edge
  // capture on rise
  always @(posedge outputPixelClock or posedge clear) begin
    if (clear) begin
      pixCount <= 16'h0000;
      firstPix <= 12'h000;
    end else if (rowActiveFlag) begin
      if (pixCount == 16'h0000) firstPix <= pixData;
      pixCount <= pixCount + 16'h0001;
    end
  end
endmodule

//--- test_poi_pixel_output.sv
`timescale 1ns/10ps
module test_poi_pixel_output;
  typedef struct {logic [1:0] fmt; logic [15:0] cols; logic [11:0] exp;} poi_case_s;
  poi_case_s   tbl [3] = '{'{2'h0, 16'h0004, 12'hAB0}, '{2'h1, 16'h0003, 12'hABC},
                          '{2'h2, 16'h0002, 12'hABD}};
  logic        clk = 0, reset = 1, clkEn = 1, standby = 1, dllLocked = 0, clear = 1;
  logic        pixInValid = 0, serial = 0;
  logic [1:0]  fmt = 0, pclkDly = 1, lanes = 0, wmode = 1;
  logic [15:0] cols = 4, hBlank = 2, rows = 2, vBlank = 1;
  logic [11:0] cfgLaneDelay = 0, pixIn = 12'hABD;
  logic [2:0]  cfgClkLaneDelay = 0;
  logic        pixInReady, rowActiveFlag, frameActiveFlag, outputPixelClock, underrun;
  logic        clkLaneRun;
  logic [11:0] pixData, firstPix;
  logic [15:0] laneDelayCode, pixCount, serWord;
  logic [3:0]  clkLaneDelayCode, laneRise, laneFall;
  int          badCount = 0, compares = 0, n;
  always #2 clk = ~clk;
  poi_pixel_output u_poi_pixel_output (.clk(clk), .reset(reset), .clkEn(clkEn),
    .standby(standby), .cfgSerialMode(serial), .cfgLaneCount(lanes), .cfgWordMode(wmode),
    .cfgRawFormat(fmt), .cfgActiveCols(cols), .cfgHBlank(hBlank), .cfgActiveRows(rows),
    .cfgVBlank(vBlank), .cfgPixClkDelay(pclkDly), .cfgLaneDelay(cfgLaneDelay),
    .cfgClkLaneDelay(cfgClkLaneDelay), .dllLocked(dllLocked), .pixIn(pixIn),
    .pixInValid(pixInValid), .pixInReady(pixInReady), .rowActiveFlag(rowActiveFlag),
    .frameActiveFlag(frameActiveFlag), .pixData(pixData), .outputPixelClock(outputPixelClock),
    .laneRise(laneRise), .laneFall(laneFall), .clkLaneRun(clkLaneRun),
    .laneDelayCode(laneDelayCode), .clkLaneDelayCode(clkLaneDelayCode), .underrun(underrun));
  poi_rx_model u_poi_rx_model (.clk(clk), .outputPixelClock(outputPixelClock), .clear(clear),
    .rowActiveFlag(rowActiveFlag), .pixData(pixData), .laneRise(laneRise[0]),
    .laneFall(laneFall[0]), .pixCount(pixCount), .firstPix(firstPix), .serWord(serWord));
  // one comparison, counted; a mismatch is reported at once
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (badCount == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for one whole frame to pass
  task wait_frame;
    for (int k = 0; k < 400 && !frameActiveFlag; k++) @(negedge clk);
    for (int k = 0; k < 400 && frameActiveFlag; k++) @(negedge clk);
  endtask
  initial begin
    #40000;
    badCount++;
    close_out;
  end
  initial begin
    repeat (12) @(negedge clk);
    reset = 0;
    // sizes and format only move in standby
    // standby setup
    for (int i = 0; i < 3; i++) begin
      standby = 1; clear = 1; fmt = tbl[i].fmt; cols = tbl[i].cols; pixInValid = 1;
      repeat (3) @(negedge clk);
      // leave standby after a pixel clock fall so prefetch beats the slot edge
      @(negedge outputPixelClock);
      @(negedge clk);
      standby = 0; clear = 0;
      wait_frame;
      check(frameActiveFlag, 16'h0000);
      check(firstPix, tbl[i].exp);
      check(pixCount, 16'(tbl[i].cols * 2));
      check(pixInReady, 0);
    end
    // starve the buffer: empty slots give zero and a sticky flag
    pixInValid = 0;
    wait_frame;
    wait_frame;
    check(underrun, 1);
    standby = 1;
    repeat (2) @(negedge clk);
    check(underrun, 0);
    // pixel clock keeps running while idle
    n = 0;
    fork : cnt
      forever @(posedge outputPixelClock) n++;
      repeat (40) @(negedge clk);
    join_any
    disable cnt;
    check(16'(n), 10);
    cfgLaneDelay = 12'h5A3; cfgClkLaneDelay = 3'h3;
    repeat (4) @(negedge clk);
    check(laneDelayCode, 0);
    check(clkLaneDelayCode, 4);
    dllLocked = 1;
    repeat (2) @(negedge clk);
    check(laneDelayCode, 16'h2643);
    check(clkLaneDelayCode, 7);
    // back to zero codes when no skew trim is needed
    // zero codes
    cfgLaneDelay = 0; cfgClkLaneDelay = 0;
    repeat (2) @(negedge clk);
    check(laneDelayCode, 0);
    // serial path: four lanes, 16-bit words, sync word then pixel
    standby = 1; clear = 1; serial = 1; lanes = 2'h2; wmode = 2'h3; fmt = 2'h2;
    pixInValid = 1;
    repeat (3) @(negedge clk);
    standby = 0; clear = 0;
    repeat (60) @(negedge clk);
    check(serWord, 16'hABD0);
    check(clkLaneRun, 16'h0001);
    // mid-run reset: outputs back to their reset values
    reset = 1;
    repeat (2) @(negedge clk);
    check(pixInReady, 16'h0001);
    check(clkLaneRun, 16'h0000);
    check(clkLaneDelayCode, 16'h0004);
    reset = 0;
    repeat (20) @(negedge clk);
    check(16'(laneRise), 16'h0000);
    close_out;
  end
endmodule
